// [design/mms_monitor_mux.sv]
// Monitor multiplexer select logic with register port
`default_nettype none
module mms_monitor_mux
    import mms_pkg::*;
#(
    parameter int SEL_W = 4
) (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire logic clk_en_i,
    // Register port
    input wire logic [3:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [7:0] reg_rdata_o,
    // Device status inputs
    input wire logic main_bias_i,
    input wire logic charging_flag_i,
    input wire logic [3:0] charger_state_details_i,
    input wire logic [1:0] input_supply_details_i,
    // Analog switch controls
    output logic [SRC_COUNT-1:0] route_en_o,
    output logic monitor_buf_en_o,
    output logic monitor_output_pin_oe_o,
    output logic thermistor_bias_en_o,
    output logic [3:0] discharge_fullscale_field_o
);
    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    logic [SEL_W-1:0] sel_q;
    logic [SEL_W-1:0] sel_d;
    logic [3:0] dscale_q;
    logic [3:0] dscale_d;
    logic [7:0] rdata_q;
    logic [7:0] rdata_d;
    logic [SRC_COUNT-1:0] route_q;
    logic [SRC_COUNT-1:0] route_d;
    logic buf_q;
    logic buf_d;
    logic thermistor_bias_pin_q;
    logic thermistor_bias_pin_d;
    logic valid_sel;
    logic charging;

    always_comb begin
        sel_d = sel_q;
        dscale_d = dscale_q;
        rdata_d = rdata_q;
        if (reg_wr_i && reg_addr_i == ADDR_SELECT) begin
            sel_d = reg_wdata_i[SEL_W-1:0];
        end
        if (reg_wr_i && reg_addr_i == ADDR_DISCHG) begin
            dscale_d = reg_wdata_i[3:0];
        end
        if (reg_rd_i) begin
            case (reg_addr_i)
                ADDR_SELECT: rdata_d = {4'h0, sel_q};
                ADDR_DISCHG: rdata_d = {4'h0, dscale_q};
                ADDR_STATUS: begin
                    rdata_d = 8'h00;
                    rdata_d[ST_BUF_EN] = buf_q;
                    rdata_d[ST_THERMISTOR_BIAS_PIN] = thermistor_bias_pin_q;
                    rdata_d[ST_CHARGING] = charging;
                    rdata_d[ST_VALID_SEL] = valid_sel;
                end
                default: rdata_d = UNMAPPED_RDATA;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Routing decode
    // ----------------------------------------------------------------
    // Codes 1..10 valid; zero and 11..15 are off
    assign valid_sel = (sel_q != SEL_OFF) && (sel_q <= SEL_SYS_V);
    // Charging decode exposed for host convenience
    assign charging = charging_flag_i
        && charger_state_details_i >= CHG_DTLS_LO
        && charger_state_details_i <= CHG_DTLS_HI
        && input_supply_details_i == INPUT_OK;

    genvar g;
    generate
        for (g = 0; g < SRC_COUNT; g++) begin : g_route
            // One-hot: bit g follows code g+1, charger state ignored
            assign route_d[g] = (sel_q == SEL_W'(g + 1));
        end
    endgenerate

    always_comb begin
        buf_d = main_bias_i && valid_sel;
        thermistor_bias_pin_d = (sel_q == SEL_THM_V) || (sel_q == SEL_THERMISTOR_BIAS_PIN_V);
    end

    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            sel_q <= SEL_OFF;
            dscale_q <= DISCHG_RESET;
            rdata_q <= 8'h00;
            route_q <= '0;
            buf_q <= 1'b0;
            thermistor_bias_pin_q <= 1'b0;
        end else if (clk_en_i) begin
            sel_q <= sel_d;
            dscale_q <= dscale_d;
            rdata_q <= rdata_d;
            route_q <= route_d;
            buf_q <= buf_d;
            thermistor_bias_pin_q <= thermistor_bias_pin_d;
        end
    end

    assign reg_rdata_o = rdata_q;
    assign route_en_o = route_q;
    assign monitor_buf_en_o = buf_q;
    assign monitor_output_pin_oe_o = buf_q;
    assign thermistor_bias_en_o = thermistor_bias_pin_q;
    assign discharge_fullscale_field_o = dscale_q;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rst_n_i);

    // ----------------------------------------------------------------
    // Off state and buffer
    // ----------------------------------------------------------------
    a_off_hiz: assert property (
        clk_en_i && sel_q == SEL_OFF
        |=> !monitor_output_pin_oe_o && route_en_o == '0
    )
        else $error("Code zero left pin driven");

    a_off_nobuf: assert property (
        clk_en_i && sel_q == SEL_OFF
        |=> !monitor_buf_en_o
    )
        else $error("Code zero left buffer on");

    a_buf_bias: assert property (
        clk_en_i && !main_bias_i
        |=> !monitor_buf_en_o
    )
        else $error("Buffer on without main bias");

    a_bias_on: assert property (
        clk_en_i && main_bias_i && valid_sel
        |=> monitor_buf_en_o && monitor_output_pin_oe_o
    )
        else $error("Buffer off with bias and valid code");

    a_rd_status: assert property (
        clk_en_i && reg_rd_i && reg_addr_i == ADDR_STATUS
        |=> reg_rdata_o[ST_BUF_EN] == $past(monitor_buf_en_o)
    )
        else $error("Status buffer bit wrong");

    // ----------------------------------------------------------------
    // Routing
    // ----------------------------------------------------------------
    a_route_onehot: assert property (
        clk_en_i && valid_sel
        |=> $onehot(route_en_o) && route_en_o[$past(sel_q) - 1]
    )
        else $error("Route not matching select");

    a_write_sel: assert property (
        clk_en_i && reg_wr_i
        && reg_addr_i == ADDR_SELECT && main_bias_i
        && reg_wdata_i[3:0] == SEL_BATTERY_PIN_V
        ##1 clk_en_i && main_bias_i
        |=> monitor_buf_en_o
    )
        else $error("Write did not enable buffer in two cycles");

    a_route_hold: assert property (
        !clk_en_i
        |=> $stable(route_en_o) && $stable(monitor_buf_en_o)
    )
        else $error("Outputs moved while clock enable low");

    a_rd_select: assert property (
        clk_en_i && reg_rd_i && reg_addr_i == ADDR_SELECT
        |=> reg_rdata_o[3:0] == 4'($past(sel_q))
    )
        else $error("Select read back wrong");

    // ----------------------------------------------------------------
    // Discharge full scale
    // ----------------------------------------------------------------
    a_dscale_rst: assert property (
        $rose(rst_n_i)
        |-> discharge_fullscale_field_o == DISCHG_RESET
    )
        else $error("Discharge scale reset wrong");

    a_dscale_wr: assert property (
        clk_en_i && reg_wr_i && reg_addr_i == ADDR_DISCHG
        |=> discharge_fullscale_field_o == $past(reg_wdata_i[3:0])
    )
        else $error("Discharge scale write lost");

    a_dscale_hold: assert property (
        !(clk_en_i && reg_wr_i && reg_addr_i == ADDR_DISCHG)
        |=> $stable(discharge_fullscale_field_o)
    )
        else $error("Discharge scale changed without write");

    // ----------------------------------------------------------------
    // Battery current channels
    // ----------------------------------------------------------------
    a_any_mode: assert property (
        clk_en_i && sel_q == SEL_BATTERY_PIN_DIS_I && main_bias_i
        |=> monitor_buf_en_o && route_en_o[4]
    )
        else $error("Battery channel blocked");

    a_chg_mode: assert property (
        clk_en_i && sel_q == SEL_BATTERY_PIN_CHG_I && main_bias_i
        |=> monitor_buf_en_o && route_en_o[3]
    )
        else $error("Charge current channel blocked");

    // ----------------------------------------------------------------
    // Thermistor bias
    // ----------------------------------------------------------------
    a_thm_bias: assert property (
        clk_en_i && (sel_q == SEL_THM_V || sel_q == SEL_THERMISTOR_BIAS_PIN_V)
        |=> thermistor_bias_en_o
    )
        else $error("Thermistor not biased");

    a_thermistor_bias_pin_off: assert property (
        clk_en_i && sel_q != SEL_THM_V && sel_q != SEL_THERMISTOR_BIAS_PIN_V
        |=> !thermistor_bias_en_o
    )
        else $error("Thermistor biased without its channel");

    // ----------------------------------------------------------------
    // Undefined codes
    // ----------------------------------------------------------------
    a_undef_off: assert property (
        clk_en_i && sel_q > SEL_SYS_V
        |=> !monitor_buf_en_o && route_en_o == '0
    )
        else $error("Undefined code not off");

    a_undef_hiz: assert property (
        clk_en_i && sel_q > SEL_SYS_V
        |=> !monitor_output_pin_oe_o
    )
        else $error("Undefined code drove the pin");

    // ----------------------------------------------------------------
    // Scenario covers
    // ----------------------------------------------------------------
    c_null: cover property (
        sel_q == SEL_BATTERY_PIN_NULL ##[1:20] sel_q == SEL_BATTERY_PIN_DIS_I
    );

    c_chg: cover property (sel_q == SEL_BATTERY_PIN_CHG_I && monitor_buf_en_o);

    c_thm: cover property (thermistor_bias_en_o && monitor_buf_en_o);

    c_idle: cover property ($fell(monitor_buf_en_o));

endmodule : mms_monitor_mux
`default_nettype wire

// [design/mms_pkg.sv]
// Package with select codes, register map and reset values
`default_nettype none
package mms_pkg;
    // ----------------------------------------------------------------
    // Select codes
    // ----------------------------------------------------------------
    localparam logic [3:0] SEL_OFF = 4'h0;
    localparam logic [3:0] SEL_CHARGER_INPUT_PIN_V = 4'h1;
    localparam logic [3:0] SEL_CHARGER_INPUT_PIN_I = 4'h2;
    localparam logic [3:0] SEL_BATTERY_PIN_V = 4'h3;
    localparam logic [3:0] SEL_BATTERY_PIN_CHG_I = 4'h4;
    localparam logic [3:0] SEL_BATTERY_PIN_DIS_I = 4'h5;
    localparam logic [3:0] SEL_BATTERY_PIN_NULL = 4'h6;
    localparam logic [3:0] SEL_THM_V = 4'h7;
    localparam logic [3:0] SEL_THERMISTOR_BIAS_PIN_V = 4'h8;
    localparam logic [3:0] SEL_ANALOG_GROUND_PIN_V = 4'h9;
    localparam logic [3:0] SEL_SYS_V = 4'ha;
    localparam int SRC_COUNT = 10;
    // ----------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------
    localparam logic [3:0] ADDR_SELECT = 4'h0;
    localparam logic [3:0] ADDR_DISCHG = 4'h1;
    localparam logic [3:0] ADDR_STATUS = 4'h2;
    localparam logic [3:0] DISCHG_RESET = 4'hf;
    localparam logic [7:0] UNMAPPED_RDATA = 8'h00;
    // Status field positions
    localparam int ST_BUF_EN = 0;
    localparam int ST_THERMISTOR_BIAS_PIN = 1;
    localparam int ST_CHARGING = 2;
    localparam int ST_VALID_SEL = 3;
    // ----------------------------------------------------------------
    // Charging decode values
    // ----------------------------------------------------------------
    localparam logic [3:0] CHG_DTLS_LO = 4'h1;
    localparam logic [3:0] CHG_DTLS_HI = 4'h7;
    localparam logic [1:0] INPUT_OK = 2'h3;
endpackage : mms_pkg
`default_nettype wire

// [testbench/mms_adc_model.sv]
// External converter that samples the monitor pin once settled
`default_nettype none
module mms_adc_model
    import mms_pkg::*;
#(
    parameter int SETTLE = 3
) (
    // Clock
    input wire logic core_clk_i,
    // Monitor side
    input wire logic [SRC_COUNT-1:0] route_en_i,
    input wire logic pin_oe_i,
    // Conversion allowed
    output logic ready_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [SRC_COUNT-1:0] last_q = '0;
    int wait_q = 0;
    always @(posedge core_clk_i) begin
        last_q <= route_en_i;
        if (route_en_i != last_q) wait_q <= 0;
        else if (wait_q < SETTLE) wait_q <= wait_q + 1;
    end
    // No conversion while the pin floats or the channel is switching
    // A fresh change is seen at once, before the counter restarts
    assign ready_o = pin_oe_i && (route_en_i == last_q)
        && (wait_q >= SETTLE);
endmodule : mms_adc_model
`default_nettype wire

// [testbench/mms_monitor_mux_bench.sv]
// Self-checking bench for the monitor multiplexer select logic
`default_nettype none
module mms_monitor_mux_bench
    import mms_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 0, rst_n = 0, en = 1, wr = 0, rd = 0, bias = 1, flg = 0;
    logic [3:0] addr = 4'h0, dtl = 4'h0, fs;
    logic [1:0] ind = 2'h0;
    logic [7:0] wd = 8'h00, rdat, v;
    logic [SRC_COUNT-1:0] rte;
    logic buf_en, oe, tb, rdy;
    int err_count = 0, total_checks = 0, cyc = 0;
    logic [9:0] rows [16] = '{10'h0, 10'h1, 10'h2, 10'h4, 10'h8, 10'h10,
        10'h20, 10'h40, 10'h80, 10'h100, 10'h200, 10'h0, 10'h0, 10'h0,
        10'h0, 10'h0};
    mms_monitor_mux dut (.core_clk_i(clk), .rst_n_i(rst_n), .clk_en_i(en),
        .reg_addr_i(addr), .reg_wdata_i(wd), .reg_wr_i(wr), .reg_rd_i(rd),
        .reg_rdata_o(rdat), .main_bias_i(bias), .charging_flag_i(flg),
        .charger_state_details_i(dtl), .input_supply_details_i(ind),
        .route_en_o(rte), .monitor_buf_en_o(buf_en),
        .monitor_output_pin_oe_o(oe), .thermistor_bias_en_o(tb),
        .discharge_fullscale_field_o(fs));
    mms_adc_model adc (.core_clk_i(clk), .route_en_i(rte), .pin_oe_i(oe),
        .ready_o(rdy));
    // ----------------------------------------------------------------
    // Bus and compare tasks
    // ----------------------------------------------------------------
    task automatic chk(input logic [9:0] g, input logic [9:0] e);
        total_checks++;
        if (g !== e) begin
            err_count++;
            $display("ERROR t=%0t got %h exp %h", $time, g, e);
        end
    endtask : chk
    task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wd <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg
    task automatic rd_reg(input logic [3:0] a);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 v = rdat;
    endtask : rd_reg
    task automatic sel(input logic [3:0] c);
        wr_reg(ADDR_SELECT, {4'h0, c});
        @(posedge clk);
        #1;
    endtask : sel
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : tally_and_finish
    // ----------------------------------------------------------------
    // Stimulus
    // ----------------------------------------------------------------
    always #50 clk = ~clk;
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            err_count++;
            tally_and_finish();
        end
    end
    initial begin
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        #1;
        chk(10'(fs), 10'(DISCHG_RESET));
        chk(10'(oe), 10'h0);
        $display("reset test done");
        for (int i = 0; i < 16; i++) begin
            sel(4'(i));
            chk(rte, rows[i]);
            chk(10'(oe), 10'(rows[i] != 10'h0));
            chk(10'(tb), 10'(i == 7 || i == 8));
        end
        $display("select table test done");
        sel(SEL_BATTERY_PIN_NULL);
        repeat (20) if (!rdy) @(posedge clk);
        chk(10'(rdy), 10'h1);
        sel(SEL_BATTERY_PIN_DIS_I);
        chk(10'(rdy), 10'h0);
        sel(SEL_BATTERY_PIN_CHG_I);
        chk(rte, 10'h8);
        @(posedge clk) bias <= 1'b0;
        @(posedge clk) #1;
        chk(10'(buf_en), 10'h0);
        @(posedge clk) bias <= 1'b1;
        $display("battery current test done");
        sel(SEL_THM_V);
        @(posedge clk);
        flg <= 1'b1;
        dtl <= CHG_DTLS_HI;
        ind <= INPUT_OK;
        rd_reg(ADDR_STATUS);
        chk(10'(v), 10'h0f);
        @(posedge clk) ind <= 2'h2;
        rd_reg(ADDR_STATUS);
        chk(10'(v), 10'h0b);
        wr_reg(ADDR_DISCHG, 8'h03);
        wr_reg(ADDR_STATUS, 8'hff);
        rd_reg(ADDR_DISCHG);
        chk(10'(v), 10'h03);
        chk(10'(fs), 10'h3);
        rd_reg(4'hc);
        chk(10'(v), 10'(UNMAPPED_RDATA));
        sel(4'hd);
        rd_reg(ADDR_SELECT);
        chk(10'(v), 10'h0d);
        chk(10'(oe), 10'h0);
        sel(SEL_OFF);
        chk(10'(oe), 10'h0);
        @(posedge clk) en <= 1'b0;
        wr_reg(ADDR_SELECT, {4'h0, SEL_BATTERY_PIN_V});
        @(posedge clk) en <= 1'b1;
        @(posedge clk) #1;
        chk(rte, 10'h0);
        sel(SEL_BATTERY_PIN_V);
        @(posedge clk) rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        #1;
        chk(10'(fs), 10'(DISCHG_RESET));
        chk(rte, 10'h0);
        $display("register test done");
        tally_and_finish();
    end
endmodule : mms_monitor_mux_bench
`default_nettype wire
